/* include/pild_defs.svh */
// constants for the post-increment load/store decoder
`ifndef PILD_DEFS_SVH
`define PILD_DEFS_SVH

// ****************************************************************
// opcodes and function codes
// ****************************************************************
`define PILD_OPC_LD_IMM    7'h0b
`define PILD_OPC_CUSTOM    7'h2b
`define PILD_F3_REG        3'h3
`define PILD_F3_LB         3'h0
`define PILD_F3_LBU        3'h4
`define PILD_F3_LH         3'h1
`define PILD_F3_LHU        3'h5
`define PILD_F3_LW         3'h2
`define PILD_F3_SB         3'h0
`define PILD_F3_SH         3'h1
`define PILD_F3_SW         3'h2

// ****************************************************************
// upper function field layout for the register forms
// ****************************************************************
`define PILD_F7_TOP_HI     6
`define PILD_F7_TOP_LO     5
`define PILD_F7_STORE_BIT  4
`define PILD_F7_UNS_BIT    3
`define PILD_F7_IDX_BIT    2
`define PILD_F7_SIZE_HI    1
`define PILD_F7_SIZE_LO    0
`define PILD_F3_UNS_BIT    2

// ****************************************************************
// instruction fields
// ****************************************************************
`define PILD_OPC_HI        6
`define PILD_OPC_LO        0
`define PILD_RD_HI         11
`define PILD_RD_LO         7
`define PILD_F3_HI         14
`define PILD_F3_LO         12
`define PILD_RS1_HI        19
`define PILD_RS1_LO        15
`define PILD_F7_HI         31
`define PILD_F7_LO         25
`define PILD_IMM_HI        31
`define PILD_IMM_LO        20

// ****************************************************************
// byte enables and reset values
// ****************************************************************
`define PILD_BE_BYTE       4'h1
`define PILD_BE_HALF       4'h3
`define PILD_BE_WORD       4'hf
`define PILD_RST_WORD      32'h0000_0000
`define PILD_RST_IDX       5'h00

`endif

/* include/pild_pkg.sv */
// types shared by the post-increment load/store decoder
package pild_pkg;

    typedef enum logic [1:0] {
        PILD_SZ_BYTE = 2'h0,
        PILD_SZ_HALF = 2'h1,
        PILD_SZ_WORD = 2'h2
    } pild_size_type;

    // gray along idle -> request -> wait; wait -> idle flips both bits
    typedef enum logic [1:0] {
        PILD_ST_IDLE = 2'h0,
        PILD_ST_REQ  = 2'h1,
        PILD_ST_WAIT = 2'h3
    } pild_state_type;

endpackage

/* rtl/pild_lane.sv */
// byte lane steering for stores and extension for loads
`timescale 1ns/1ps
`include "pild_defs.svh"

module pild_lane
    import pild_pkg::*;
(
    input  wire pild_size_type size_i,
    input  wire logic          uns_i,
    input  wire logic [1:0]    addr_lo_i,
    input  wire logic [31:0]   sdata_i,
    input  wire logic [31:0]   rdata_i,
    output logic      [3:0]    be_o,
    output logic      [31:0]   wdata_o,
    output logic      [31:0]   ldata_o
);
    wire [4:0]  shift_w  = {addr_lo_i, 3'h0};
    wire [31:0] rsh_w    = rdata_i >> shift_w;
    wire        bsign_w  = ~uns_i & rsh_w[7];
    wire        hsign_w  = ~uns_i & rsh_w[15];
    wire [31:0] lb_w     = {{24{bsign_w}}, rsh_w[7:0]};
    wire [31:0] lh_w     = {{16{hsign_w}}, rsh_w[15:0]};
    wire [3:0]  be_b_w   = `PILD_BE_BYTE << addr_lo_i;
    wire [3:0]  be_h_w   = `PILD_BE_HALF << {addr_lo_i[1], 1'b0};

    // loads: extended by size and signedness
    assign ldata_o = (size_i == PILD_SZ_BYTE) ? lb_w :
                     (size_i == PILD_SZ_HALF) ? lh_w : rdata_i;
    // stores: low byte or half of the source replicated across the lanes; words pass through unchanged
    assign wdata_o = (size_i == PILD_SZ_BYTE) ? {4{sdata_i[7:0]}} :
                     (size_i == PILD_SZ_HALF) ? {2{sdata_i[15:0]}} :
                     sdata_i;
    assign be_o    = (size_i == PILD_SZ_BYTE) ? be_b_w :
                     (size_i == PILD_SZ_HALF) ? be_h_w : `PILD_BE_WORD;
endmodule

/* rtl/pild_top.sv */
// post-increment and indexed load/store decode and execution
//
// Functional notes
// - access at old base, then write back increment
// - base from register; offset immediate or register
// - instructions exist only when extension enabled
// - same register: loaded data beats increment
// - immediate post-inc load, base += sext imm
// - register post-inc load, base += second source
// - immediate post-inc store, base += sext imm
// - register post-inc store, base += third source
// - immediate loads: opcode 0x0b, funct3 variants
// - register post-inc loads: opcode 0x2b, funct3 3
// - indexed loads at base plus rs2, no update
// - immediate stores: opcode 0x2b, split offset
// - register post-inc stores, third source bits 11:7
// - indexed stores at base plus third source
`timescale 1ns/1ps
`include "pild_defs.svh"

module pild_top
    import pild_pkg::*;
#(
    parameter int CUSTOM_EXT_ENABLE = 1
)(
    input  wire logic        clock_i,
    input  wire logic        arst_n_i,
    input  wire logic        instr_valid_i,
    input  wire logic [31:0] instr_i,
    input  wire logic [31:0] rs1_value_i,
    input  wire logic [31:0] rs2_value_i,
    input  wire logic [31:0] rs3_value_i,
    output logic             instr_ready_o,
    output logic             illegal_o,
    output logic             fault_o,
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic      [31:0] mem_addr_o,
    output logic      [3:0]  mem_be_o,
    output logic      [31:0] mem_wdata_o,
    input  wire logic        mem_gnt_i,
    input  wire logic        mem_rvalid_i,
    input  wire logic        mem_err_i,
    input  wire logic [31:0] mem_rdata_i,
    output logic             rf_ld_en_o,
    output logic      [4:0]  rf_ld_idx_o,
    output logic      [31:0] rf_ld_data_o,
    output logic             rf_inc_en_o,
    output logic      [4:0]  rf_inc_idx_o,
    output logic      [31:0] rf_inc_data_o
);
    // refused at elaboration: the enable is a strict on/off switch
    if (CUSTOM_EXT_ENABLE != 0 && CUSTOM_EXT_ENABLE != 1) begin
        $error("CUSTOM_EXT_ENABLE must be 0 or 1");
    end

    // ************************************************************
    // decode
    // ************************************************************
    wire [6:0] opc_w = instr_i[`PILD_OPC_HI:`PILD_OPC_LO];
    wire [2:0] f3_w  = instr_i[`PILD_F3_HI:`PILD_F3_LO];
    wire [6:0] f7_w  = instr_i[`PILD_F7_HI:`PILD_F7_LO];
    wire [4:0] rd_w  = instr_i[`PILD_RD_HI:`PILD_RD_LO];
    wire [4:0] b_w   = instr_i[`PILD_RS1_HI:`PILD_RS1_LO];

    // immediate loads: funct3 000/100/001/101/010
    wire ld_imm_w = (opc_w == `PILD_OPC_LD_IMM) &&
        (f3_w == `PILD_F3_LB || f3_w == `PILD_F3_LBU ||
         f3_w == `PILD_F3_LH || f3_w == `PILD_F3_LHU ||
         f3_w == `PILD_F3_LW);
    // immediate stores: funct3 000/001/010
    wire st_imm_w = (opc_w == `PILD_OPC_CUSTOM) &&
        (f3_w == `PILD_F3_SB || f3_w == `PILD_F3_SH ||
         f3_w == `PILD_F3_SW);
    // register forms share one upper-field layout
    wire f7_st_w  = f7_w[`PILD_F7_STORE_BIT];
    wire f7_un_w  = f7_w[`PILD_F7_UNS_BIT];
    wire f7_ix_w  = f7_w[`PILD_F7_IDX_BIT];
    wire [1:0] f7_sz_w = f7_w[`PILD_F7_SIZE_HI:`PILD_F7_SIZE_LO];
    wire reg_w = (opc_w == `PILD_OPC_CUSTOM) &&
        (f3_w == `PILD_F3_REG) &&
        (f7_w[`PILD_F7_TOP_HI:`PILD_F7_TOP_LO] == 2'h0) &&
        (f7_sz_w != 2'h3) &&
        !(f7_un_w && (f7_st_w || f7_sz_w == 2'h2));
    // whole family gated by the extension switch
    wire en_w    = (CUSTOM_EXT_ENABLE == 1);
    wire legal_w = en_w && (ld_imm_w || st_imm_w || reg_w);
    wire take_w  = instr_valid_i && instr_ready_o;

    wire                is_st_w  = st_imm_w || (reg_w && f7_st_w);
    wire                is_idx_w = reg_w && f7_ix_w;
    wire                uns_w    = reg_w ? f7_un_w :
                                   f3_w[`PILD_F3_UNS_BIT];
    wire pild_size_type size_w   = reg_w ? pild_size_type'(f7_sz_w) :
                                   pild_size_type'(f3_w[1:0]);
    wire [11:0] ld_imm12_w = instr_i[`PILD_IMM_HI:`PILD_IMM_LO];
    wire [11:0] st_imm12_w = {f7_w, rd_w};
    // offset: sext immediate, rs2 for loads, rs3 for stores
    wire [31:0] off_w = ld_imm_w ? {{20{ld_imm12_w[11]}}, ld_imm12_w} :
                        st_imm_w ? {{20{st_imm12_w[11]}}, st_imm12_w} :
                        f7_st_w  ? rs3_value_i : rs2_value_i;
    wire [31:0] sum_w  = rs1_value_i + off_w;
    // post-inc forms use the untouched base
    wire [31:0] ea_w   = is_idx_w ? sum_w : rs1_value_i;

    // ************************************************************
    // captured instruction
    // ************************************************************
    pild_state_type state_r;
    pild_size_type  size_r;
    logic           uns_r;
    logic           is_ld_r;
    logic           is_inc_r;
    logic [4:0]     rd_r;
    logic [31:0]    off_r;
    logic [3:0]     be_w;
    logic [31:0]    wdata_w;
    logic [31:0]    ldata_w;

    pild_lane u_st_lane (
        .size_i    (size_w),
        .uns_i     (uns_w),
        .addr_lo_i (ea_w[1:0]),
        .sdata_i   (rs2_value_i),
        .rdata_i   (mem_rdata_i),
        .be_o      (be_w),
        .wdata_o   (wdata_w),
        .ldata_o   ()
    );

    pild_lane u_ld_lane (
        .size_i    (size_r),
        .uns_i     (uns_r),
        .addr_lo_i (mem_addr_o[1:0]),
        .sdata_i   (`PILD_RST_WORD),
        .rdata_i   (mem_rdata_i),
        .be_o      (),
        .wdata_o   (),
        .ldata_o   (ldata_w)
    );

    // ************************************************************
    // completion
    // ************************************************************
    wire done_w   = (state_r == PILD_ST_WAIT) && mem_rvalid_i;
    // faulting access changes no register
    wire ok_w     = done_w && !mem_err_i;
    wire ld_wr_w  = ok_w && is_ld_r && (rd_r != 5'h00);
    // loaded data wins a shared destination
    wire inc_wr_w = ok_w && is_inc_r &&
                    (rf_inc_idx_o != 5'h00) &&
                    !(is_ld_r && rd_r == rf_inc_idx_o);

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r       <= PILD_ST_IDLE;
            instr_ready_o <= 1'b1;
            mem_req_o     <= 1'b0;
        end else begin
            case (state_r)
                PILD_ST_IDLE: begin
                    if (take_w && legal_w) begin
                        state_r       <= PILD_ST_REQ;
                        instr_ready_o <= 1'b0;
                        mem_req_o     <= 1'b1;
                    end
                end
                PILD_ST_REQ: begin
                    if (mem_gnt_i) begin
                        state_r   <= PILD_ST_WAIT;
                        mem_req_o <= 1'b0;
                    end
                end
                PILD_ST_WAIT: begin
                    if (mem_rvalid_i) begin
                        state_r       <= PILD_ST_IDLE;
                        instr_ready_o <= 1'b1;
                    end
                end
                default: begin
                    state_r       <= PILD_ST_IDLE;
                    instr_ready_o <= 1'b1;
                    mem_req_o     <= 1'b0;
                end
            endcase
        end
    end

    // capture; address and offset held until the next legal instruction
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            size_r       <= PILD_SZ_WORD;
            uns_r        <= 1'b0;
            is_ld_r      <= 1'b0;
            is_inc_r     <= 1'b0;
            rd_r         <= `PILD_RST_IDX;
            off_r        <= `PILD_RST_WORD;
            mem_we_o     <= 1'b0;
            mem_addr_o   <= `PILD_RST_WORD;
            mem_be_o     <= 4'h0;
            mem_wdata_o  <= `PILD_RST_WORD;
            rf_inc_idx_o <= `PILD_RST_IDX;
        end else if (take_w && legal_w) begin
            size_r       <= size_w;
            uns_r        <= uns_w;
            is_ld_r      <= !is_st_w;
            is_inc_r     <= !is_idx_w;
            rd_r         <= rd_w;
            off_r        <= off_w;
            mem_we_o     <= is_st_w;
            mem_addr_o   <= ea_w;
            mem_be_o     <= is_st_w ? be_w : `PILD_BE_WORD;
            mem_wdata_o  <= wdata_w;
            rf_inc_idx_o <= b_w;
        end
    end

    // one-cycle result pulses
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            illegal_o     <= 1'b0;
            fault_o       <= 1'b0;
            rf_ld_en_o    <= 1'b0;
            rf_ld_idx_o   <= `PILD_RST_IDX;
            rf_ld_data_o  <= `PILD_RST_WORD;
            rf_inc_en_o   <= 1'b0;
            rf_inc_data_o <= `PILD_RST_WORD;
        end else begin
            illegal_o     <= take_w && !legal_w;
            fault_o       <= done_w && mem_err_i;
            rf_ld_en_o    <= ld_wr_w;
            rf_ld_idx_o   <= rd_r;
            rf_ld_data_o  <= ldata_w;
            // second register-file update
            rf_inc_en_o   <= inc_wr_w;
            rf_inc_data_o <= mem_addr_o + off_r;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    AST_REQ_HOLD: assert property (
        mem_req_o && !mem_gnt_i |=> mem_req_o && $stable(mem_addr_o))
        else $error("request dropped or address moved before grant");
    AST_OFF_NO_MEM: assert property (
        !en_w |-> !mem_req_o && !rf_ld_en_o && !rf_inc_en_o)
        else $error("activity with extension disabled");
    AST_ILLEGAL: assert property (
        take_w && !legal_w |=> illegal_o && !mem_req_o)
        else $error("illegal encoding not flagged");
    AST_POSTINC_BASE: assert property (
        take_w && legal_w && !is_idx_w |=>
            mem_req_o && mem_addr_o == $past(rs1_value_i))
        else $error("post-increment access not at base");
    AST_IDX_ADDR: assert property (
        take_w && legal_w && is_idx_w |=>
            mem_addr_o == $past(rs1_value_i) +
                ($past(f7_st_w) ? $past(rs3_value_i) :
                                  $past(rs2_value_i)))
        else $error("indexed address wrong");
    AST_FAULT_NO_WB: assert property (
        done_w && mem_err_i |=> fault_o && !rf_inc_en_o && !rf_ld_en_o)
        else $error("faulting access updated registers");
    AST_SAME_REG: assert property (
        rf_inc_en_o |-> !(rf_ld_en_o && rf_ld_idx_o == rf_inc_idx_o))
        else $error("increment overwrote loaded data");
    AST_INC_VALUE: assert property (
        rf_inc_en_o |-> rf_inc_data_o == mem_addr_o + off_r)
        else $error("increment value wrong");
    AST_STORE_NO_LOAD: assert property (
        rf_ld_en_o |-> !mem_we_o && instr_ready_o)
        else $error("store wrote destination register");
    AST_WAIT_BOUND: assert property (
        mem_req_o && mem_gnt_i |=> !mem_req_o && !instr_ready_o)
        else $error("request held after grant");

    COV_LD_INC: cover property (rf_ld_en_o && rf_inc_en_o);
    COV_ST_INC: cover property (rf_inc_en_o && mem_we_o);
    COV_SAME: cover property (ok_w && is_ld_r && is_inc_r &&
                              rd_r == rf_inc_idx_o && rd_r != 5'h00);
    COV_FAULT: cover property (fault_o);
endmodule

/* bench/pild_mem_model.sv */
// data memory partner model for the load/store decoder
`timescale 1ns/1ps

module pild_mem_model (
    input  wire logic        clock_i,
    input  wire logic        arst_n_i,
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [3:0]  be_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic [1:0]  gnt_dly_i,
    input  wire logic [1:0]  rsp_dly_i,
    input  wire logic        err_cmd_i,
    output logic             gnt_o,
    output logic             rvalid_o,
    output logic             err_o,
    output logic      [31:0] rdata_o
);
    logic [31:0] mem_q [64];
    logic [1:0]  cnt_r;
    logic        pend_r;
    logic        we_r;
    logic [5:0]  idx_r;
    logic [3:0]  be_r;
    logic [31:0] wd_r;

    // outside a response, data and error toggle so stale values never match
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {cnt_r, pend_r, gnt_o, rvalid_o, err_o} <= '0;
            rdata_o <= 32'h5a5a_0ff0;
        end else begin
            gnt_o    <= 1'b0;
            rvalid_o <= 1'b0;
            err_o    <= ~err_o;
            rdata_o  <= ~rdata_o;
            if (req_i && !gnt_o && !pend_r) begin
                cnt_r <= cnt_r + 2'h1;
                if (cnt_r >= gnt_dly_i) begin
                    {gnt_o, pend_r, cnt_r} <= 4'hc;
                    {we_r, idx_r, be_r, wd_r} <=
                        {we_i, addr_i[7:2], be_i, wdata_i};
                end
            end else if (pend_r) begin
                cnt_r <= cnt_r + 2'h1;
                if (cnt_r >= rsp_dly_i) begin
                    {rvalid_o, pend_r, cnt_r} <= 4'h8;
                    err_o   <= err_cmd_i;
                    rdata_o <= mem_q[idx_r];
                    // a failed store leaves memory untouched
                    for (int b = 0; b < 4; b++)
                        if (we_r && be_r[b] && !err_cmd_i)
                            mem_q[idx_r][8*b +: 8] <= wd_r[8*b +: 8];
                end
            end
        end
    end
endmodule

/* bench/pild_top_tb.sv */
// self-checking bench for the post-increment load/store decoder
`timescale 1ns/1ps

module pild_top_tb;
    logic        clock_i, arst_n_i, valid, err_cmd;
    logic [31:0] instr, rs1, rs2, rs3, addr, wdata, rdata;
    logic [31:0] ld_data, inc_data;
    logic [1:0]  gdly, rdly;
    logic        ready, ill, fault, req, we, gnt, rvalid, merr;
    logic        ld_en, inc_en, ill_off, req_off;
    logic [3:0]  be;
    logic [4:0]  ld_idx, inc_idx;
    logic [31:0] ref_mem [64];
    integer      seed, n_fail, num_checks, i;
    logic [31:0] ill_tab [6];

    pild_top #(.CUSTOM_EXT_ENABLE(1)) dut (.clock_i(clock_i),
        .arst_n_i(arst_n_i), .instr_valid_i(valid), .instr_i(instr),
        .rs1_value_i(rs1), .rs2_value_i(rs2), .rs3_value_i(rs3),
        .instr_ready_o(ready), .illegal_o(ill), .fault_o(fault),
        .mem_req_o(req), .mem_we_o(we), .mem_addr_o(addr), .mem_be_o(be),
        .mem_wdata_o(wdata), .mem_gnt_i(gnt), .mem_rvalid_i(rvalid),
        .mem_err_i(merr), .mem_rdata_i(rdata), .rf_ld_en_o(ld_en),
        .rf_ld_idx_o(ld_idx), .rf_ld_data_o(ld_data),
        .rf_inc_en_o(inc_en), .rf_inc_idx_o(inc_idx),
        .rf_inc_data_o(inc_data));
    // extension switched off: every word must be refused
    pild_top #(.CUSTOM_EXT_ENABLE(0)) dis (.clock_i(clock_i),
        .arst_n_i(arst_n_i), .instr_valid_i(valid), .instr_i(instr),
        .rs1_value_i(rs1), .rs2_value_i(rs2), .rs3_value_i(rs3),
        .instr_ready_o(), .illegal_o(ill_off), .fault_o(),
        .mem_req_o(req_off), .mem_we_o(), .mem_addr_o(), .mem_be_o(),
        .mem_wdata_o(), .mem_gnt_i(gnt), .mem_rvalid_i(rvalid),
        .mem_err_i(merr), .mem_rdata_i(rdata), .rf_ld_en_o(),
        .rf_ld_idx_o(), .rf_ld_data_o(), .rf_inc_en_o(), .rf_inc_idx_o(),
        .rf_inc_data_o());
    pild_mem_model mem (.clock_i(clock_i), .arst_n_i(arst_n_i),
        .req_i(req), .we_i(we), .addr_i(addr), .be_i(be), .wdata_i(wdata),
        .gnt_dly_i(gdly), .rsp_dly_i(rdly), .err_cmd_i(err_cmd),
        .gnt_o(gnt), .rvalid_o(rvalid), .err_o(merr), .rdata_o(rdata));

    // ****************************************************************
    // checking helpers
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic [31:0] ext(input logic [31:0] w,
        input logic [1:0] a, sz, input logic u);
        logic [31:0] s;
        s = w >> {a, 3'h0};
        case (sz)
            2'h0: return u ? {24'h0, s[7:0]} : {{24{s[7]}}, s[7:0]};
            2'h1: return u ? {16'h0, s[15:0]} : {{16{s[15]}}, s[15:0]};
            default: return w;
        endcase
    endfunction

    // offers one word at the current falling edge, checks the outcome
    task automatic run_op(input logic [31:0] w, input logic e);
        logic ldi, sti, rr, st, u, post, lg;
        logic [1:0]  sz;
        logic [3:0]  xbe;
        logic [31:0] off, ea, a1, xwd;
        int k;
        ldi = w[6:0] == 7'h0b;
        sti = w[6:0] == 7'h2b && w[14:12] < 3'h3;
        rr = w[6:0] == 7'h2b && w[14:12] == 3'h3 && w[31:30] == 2'h0;
        st = sti | (rr & w[29]);
        u = ldi ? w[14] : rr & w[28];
        sz = (ldi | sti) ? w[13:12] : w[26:25];
        post = !(rr && w[27]);
        lg = (ldi | sti | rr) && sz != 2'h3 && !(u && (st || sz == 2'h2));
        off = ldi ? {{20{w[31]}}, w[31:20]} : sti ?
            {{20{w[31]}}, w[31:25], w[11:7]} : st ? rs3 : rs2;
        a1 = rs1;
        ea = post ? a1 : a1 + off;
        a1 = a1 - (ea & (sz == 2'h2 ? 32'h3 : {31'h0, sz[0]}));
        ea = post ? a1 : a1 + off;
        xbe = sz == 2'h0 ? 4'h1 << ea[1:0] : sz == 2'h1 ?
            4'h3 << {ea[1], 1'b0} : 4'hf;
        xwd = sz == 2'h0 ? {4{rs2[7:0]}} : sz == 2'h1 ?
            {2{rs2[15:0]}} : rs2;
        instr <= w;
        rs1 <= a1;
        err_cmd <= e;
        valid <= 1'b1;
        @(negedge clock_i);
        valid <= 1'b0;
        chk("illegal", !lg, ill);
        chk("illegal when off", 1'b1, ill_off);
        chk("request", lg, req);
        if (lg) begin
            chk("address", ea, addr);
            chk("write", st, we);
            chk("enables", st ? xbe : 4'hf, be);
            if (st)
                chk("store data", xwd, wdata);
            for (k = 0; k < 40 && ready !== 1'b1; k++)
                @(negedge clock_i);
            chk("ready", 1'b1, ready);
            chk("fault", e, fault);
            chk("load write", !st && !e && w[11:7] != 5'h0,
                ld_en);
            if (ld_en === 1'b1) begin
                chk("load index", w[11:7], ld_idx);
                chk("load data", ext(ref_mem[ea[7:2]], ea[1:0], sz, u),
                    ld_data);
            end
            chk("inc write", post && !e && w[19:15] != 5'h0 &&
                (st || w[11:7] != w[19:15]), inc_en);
            if (inc_en === 1'b1) begin
                chk("inc index", w[19:15], inc_idx);
                chk("inc data", a1 + off, inc_data);
            end
            if (st && !e)
                for (k = 0; k < 4; k++)
                    if (xbe[k])
                        ref_mem[ea[7:2]][8*k +: 8] = xwd[8*k +: 8];
        end else begin
            @(negedge clock_i);
            chk("no writes", 2'h0, {ld_en, inc_en});
        end
        chk("request when off", 1'b0, req_off);
    endtask

    // ****************************************************************
    // clock, reset and sequence
    // ****************************************************************
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    initial begin
        #400000;
        n_fail++;
        report_and_stop;
    end

    initial begin
        logic [31:0] r, w;
        seed = 22569;
        {n_fail, num_checks} = '0;
        {arst_n_i, valid, err_cmd, gdly, rdly} = '0;
        {instr, rs1, rs2, rs3} = '0;
        for (i = 0; i < 64; i++) begin
            ref_mem[i] = $random(seed);
            mem.mem_q[i] = ref_mem[i];
        end
        // hwloop, event load, unsigned word, unsigned register word, unsigned store, base load
        ill_tab = '{32'h0000_402b, 32'h0000_300b, 32'h0000_600b,
            32'h1400_302b, 32'h3000_302b, 32'h0000_2003};
        repeat (2) @(negedge clock_i);
        chk("ready in reset", 1'b1, ready);
        chk("request in reset", 1'b0, req);
        arst_n_i = 1'b1;
        // same base and destination, then a faulting post-increment
        run_op(32'hffc2_828b, 1'b0);
        run_op(32'hffc2_828b, 1'b0);
        run_op(32'h0242_a28b, 1'b0);
        run_op(32'h0242_a28b, 1'b1);
        run_op(32'h2c62_b2ab, 1'b1);
        for (i = 0; i < 6; i++)
            run_op(ill_tab[i], 1'b0);
        for (i = 0; i < 320; i++) begin
            r = $random(seed);
            w = $random(seed);
            rs2 <= $random(seed);
            rs3 <= $random(seed);
            gdly <= r[1:0];
            rdly <= r[3:2];
            case (r[6:4])
                3'h0, 3'h1: w[6:0] = 7'h0b;
                3'h2, 3'h3: w = {w[31:15], 1'b0, r[8:7] % 2'h3, w[11:7], 7'h2b};
                3'h4, 3'h5, 3'h6: w = {2'h0, w[29:15], 3'h3, w[11:7], 7'h2b};
                default: w = w;
            endcase
            if (r[11:9] == 3'h0)
                w[11:7] = w[19:15];
            rs1 <= $random(seed);
            @(negedge clock_i);
            run_op(w, r[14:12] == 3'h0);
        end
        report_and_stop;
    end
endmodule
